// ---- dv/cio_far_side.sv ----
// Far-side model: servo receiver driving the two pulse inputs.
// Assumes the 200 MHz mclk; pulse lengths are in whole microseconds.
`timescale 1ns/1ps
module cio_far_side (
  input wire logic mclk,
  output logic servoIn1,
  output logic servoIn2
);
  initial begin
    servoIn1 = 1'b0;
    servoIn2 = 1'b0;
  end
  // Idle sits at the inverse of the active level; inverted polarity idles high
  task automatic pulse(input int ch, input int us, input logic inv);
    @(posedge mclk);
    if (ch == 1) servoIn1 <= inv;
    else servoIn2 <= inv;
    repeat (400) @(posedge mclk);
    if (ch == 1) servoIn1 <= ~inv;
    else servoIn2 <= ~inv;
    repeat (us * 200) @(posedge mclk);
    if (ch == 1) servoIn1 <= inv;
    else servoIn2 <= inv;
    repeat (400) @(posedge mclk);
  endtask : pulse
endmodule : cio_far_side

// ---- dv/test_common_io_config_and_contactor.sv ----
// Self-checking bench for the common input/output block.
// Assumes cio_pkg and cio_top; servo pulses come from cio_far_side.
`timescale 1ns/1ps
module test_common_io_config_and_contactor;
  import cio_pkg::*;
  logic mclk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, appSelect;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [79:0] pinMv = '0;
  logic [4:0] pinLevel = 5'h00, pullUpEn, pullDnEn;
  logic [15:0] chgCurRaw = 0, chgVolRaw = 0, gndioRaw = 0, battMv = 16'h3A98;
  logic [15:0] motorTempValue, toneVolume, v;
  logic flipFlopFitted = 0, servoIn1, servoIn2, contDrainOut, contDrainOe;
  logic powerSwitchOn, auxOutputTwo, powerOffReq, motorTempEn;
  logic [1:0] contExtraOn;
  int nErrors = 0, checkCount = 0, n, k;
  always #2.5 mclk = ~mclk;
  cio_top cio_top_inst (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pinMv, .pinLevel, .pullUpEn,
    .pullDnEn, .servoIn1, .servoIn2, .chgCurRaw, .chgVolRaw, .gndioRaw, .battMv,
    .flipFlopFitted, .contDrainOut, .contDrainOe, .powerSwitchOn, .contExtraOn,
    .auxOutputTwo, .powerOffReq, .motorTempEn, .motorTempValue, .toneVolume,
    .appSelect);
  cio_far_side cio_far_side_inst (.mclk, .servoIn1, .servoIn2);
  ////////////////////////////////////////////////////////////////////////////
  task automatic testDone;
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : testDone
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Tick phase against the pulse edge leaves one count of slack
  task automatic chkNear(input string what, input int exp, input logic [31:0] got);
    checkCount++;
    if (got !== 32'(exp) && got !== 32'(exp - 1)) begin
      nErrors++;
      $display("BAD %s expected %0d seen %h", what, exp, got);
    end
  endtask : chkNear
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 40) begin
      nErrors++;
      testDone();
    end
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(0, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] gdinFloat(input int mv);
    return mv > 7800 ? 3 : mv > 4200 ? 2 : mv > 2600 ? 1 : 0;
  endfunction : gdinFloat
  // PWM steps of 100 whose ramp stays under the wanted average coil voltage
  function automatic int voltSteps(input int volts, input int mv);
    int s;
    s = 0;
    for (int i = 0; i < 100; i++) if (i * mv < volts * 100000) s++;
    return s;
  endfunction : voltSteps
  task automatic contact(input int num, input logic on);
    wr(OFS_CONTCMD, 32'(num) | (32'(on) << 8));
    repeat (3) @(posedge mclk);
  endtask : contact
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(26459));
    repeat (20) @(posedge mclk);
    rst <= 0;
    rd(OFS_SIG);
    chk("signature", 32'h0000005A, q);
    rd(8'hF0);
    chk("unmapped", 32'h0, q);
    rd(OFS_APPSEL);
    chk("appsel", 32'h0, q);
    chk("appsel port", 32'h0, 32'(appSelect));
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 5; i++) wr(OFS_IOCONF0 + 8'(4 * i), 32'(c));
      chk("pullup", (c == 1) ? 32'h1F : 32'h0, 32'(pullUpEn));
      chk("pulldn", (c == 2) ? 32'h1F : 32'h0, 32'(pullDnEn));
    end
    $display("bias test done");
    for (int i = 0; i < 5; i++) wr(OFS_IOCONF0 + 8'(4 * i), 32'h1);
    pinMv <= {5{16'h0064}};
    rd(OFS_GDIN0 + 8'h08);
    chk("gdin pullup low", 32'hFFFFFFFF, q);
    for (int i = 0; i < 5; i++) wr(OFS_IOCONF0 + 8'(4 * i), 32'h0);
    rd(OFS_GDIN0 + 8'h08);
    chk("gdin float low", 32'h0, q);
    for (k = 0; k < 6; k++) begin
      n = (k == 0) ? 7801 : (k == 1) ? 2600 : int'($urandom_range(12000));
      v = 16'(n);
      pinMv <= {v ^ 16'h0001, {4{v}}};
      rd(OFS_GPIO0 + 8'h04);
      chk("gpio float", 32'(v), q);
      rd(OFS_GDIN0 + 8'h04);
      chk("gdin float", gdinFloat(n), q);
    end
    wr(OFS_IOCONF0, 32'(CONF_PULLDN));
    rd(OFS_GPIO0);
    chk("gpio pulldn", 32'(v + (v >> 4)), q);
    $display("level test done");
    wr(OFS_IOCONF0, 32'(CONF_PULSE_US));
    n = int'($urandom_range(10, 3));
    @(posedge mclk);
    pinLevel <= 5'h01;
    repeat (n * 200) @(posedge mclk);
    pinLevel <= 5'h00;
    repeat (10) @(posedge mclk);
    rd(OFS_GPIO0);
    chkNear("pulse us", n, q);
    for (int p = 0; p < 3; p++) begin
      wr(OFS_PPMCONF, (p == 2) ? 32'(PPM_INVERT) : 32'(PPM_NORMAL));
      n = int'($urandom_range(20, 2));
      cio_far_side_inst.pulse(p % 2 + 1, n, p == 2);
      rd((p % 2) ? OFS_CH2 : OFS_CH1);
      chkNear("servo", n, q);
    end
    $display("timing test done");
    chgCurRaw <= 16'($urandom);
    chgVolRaw <= 16'($urandom);
    gndioRaw <= 16'hFF9C;
    rd(OFS_ICHG);
    chk("ichg", 32'(chgCurRaw), 32'(q[15:0]));
    rd(OFS_UCHG);
    chk("uchg", 32'(chgVolRaw), 32'(q[15:0]));
    rd(OFS_GNDIO);
    chk("gndio", 32'hFFFFFF9C, q);
    wr(OFS_IDQUERY, 32'(ID_UCHG));
    rd(OFS_IDVALUE);
    chk("id uchg", 32'(chgVolRaw), 32'(q[15:0]));
    wr(OFS_IDQUERY, 32'h05);
    rd(OFS_IDVALUE);
    chk("id unknown", 32'(ID_ERROR), q);
    wr(OFS_MTEMPSEL, 32'h0);
    chk("mtemp off", 32'h0, 32'(motorTempEn));
    wr(OFS_MTEMPSEL, 32'(ID_ICHG));
    chk("mtemp on", 32'h1, 32'(motorTempEn));
    chk("mtemp val", 32'(chgCurRaw), 32'(motorTempValue));
    wr(OFS_BEEPVOL, 32'd1000);
    chk("tone max", 32'd1000, 32'(toneVolume));
    wr(OFS_BEEPVOL, 32'd1001);
    chk("tone clamp", 32'd1000, 32'(toneVolume));
    $display("reading test done");
    for (int c = 0; c < 4; c += (c == 0) ? 2 : 1) begin
      contact(c, 1);
      chk("switch", (c == 0) ? 32'h1 : 32'h1 << (c - 2), {30'h0, contExtraOn}
        + 32'(powerSwitchOn));
      rd(OFS_CONTCMD);
      chk("switch state", 32'h1 << c, 32'(q[3:0]));
      contact(c, 0);
    end
    // Cases: 1 zero duty, 2 five volts over one PWM period, 3 no pull-in time, hold 0
    for (int a = 0; a < 4; a++) begin
      wr(OFS_ATTACK, (a == 1) ? 32'h0 : (a == 2) ? 32'h000000FB : 32'(ATTACK_RST));
      if (a == 3) wr(OFS_ATTACKTIME, 32'h0);
      if (a == 3) wr(OFS_HOLD, 32'h0);
      contact(1, 1);
      n = 0;
      repeat ((a == 2) ? 20000 : 1000) begin
        @(posedge mclk);
        n += int'(contDrainOe === 1'b1);
      end
      k = (a == 0) ? 1000 : (a == 2) ? 200 * voltSteps(5, int'(battMv)) : 0;
      chk("pullin duty", 32'(k), 32'(n));
      chk("drain out", 32'h0, 32'(contDrainOut));
      wr(OFS_IDQUERY, 32'(ID_CONT));
      rd(OFS_IDVALUE);
      chk("cont state on", 32'h1, q);
      contact(1, 0);
      chk("cont off", 32'h0, 32'(contDrainOe));
      rd(OFS_IDVALUE);
      chk("cont state off", 32'h0, q);
    end
    wr(OFS_SHUTDOWN, 32'h1);
    chk("aux", 32'h1, 32'(auxOutputTwo));
    chk("no poweroff", 32'h0, 32'(powerOffReq));
    flipFlopFitted <= 1;
    wr(OFS_SHUTDOWN, 32'h1);
    chk("poweroff", 32'h1, 32'(powerOffReq));
    $display("output test done");
    testDone();
  end
endmodule : test_common_io_config_and_contactor

// ---- rtl/cio_pkg.sv ----
// Package for the common input/output block: register map, codes, thresholds, timing.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone register bus.
package cio_pkg;
  localparam int NPINS = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_SIG = 8'h00;
  localparam logic [7:0] OFS_MTEMPSEL = 8'h04;
  localparam logic [7:0] OFS_BEEPVOL = 8'h08;
  localparam logic [7:0] OFS_APPSEL = 8'h0C;
  localparam logic [7:0] OFS_PPMCONF = 8'h10;
  localparam logic [7:0] OFS_CONTCMD = 8'h14;
  localparam logic [7:0] OFS_SHUTDOWN = 8'h18;
  localparam logic [7:0] OFS_ATTACK = 8'h1C;
  localparam logic [7:0] OFS_ATTACKTIME = 8'h20;
  localparam logic [7:0] OFS_HOLD = 8'h24;
  localparam logic [7:0] OFS_CH1 = 8'h28;
  localparam logic [7:0] OFS_CH2 = 8'h2C;
  localparam logic [7:0] OFS_ICHG = 8'h30;
  localparam logic [7:0] OFS_UCHG = 8'h34;
  localparam logic [7:0] OFS_GNDIO = 8'h38;
  localparam logic [7:0] OFS_IDQUERY = 8'h3C;
  localparam logic [7:0] OFS_IDVALUE = 8'h40;
  localparam logic [7:0] OFS_IOCONF0 = 8'h80;
  localparam logic [7:0] OFS_GPIO0 = 8'hA0;
  localparam logic [7:0] OFS_GDIN0 = 8'hC0;
  // Command field positions
  localparam int CONT_NUM_LSB = 0;
  localparam int CONT_ON_BIT = 8;
  localparam int SHUT_BIT = 0;
  // Pin configuration codes
  localparam logic [15:0] CONF_FLOAT = 16'h0000;
  localparam logic [15:0] CONF_PULLUP = 16'h0001;
  localparam logic [15:0] CONF_PULLDN = 16'h0002;
  localparam logic [15:0] CONF_PULSE_US = 16'h0020;
  localparam logic [15:0] CONF_PULSE_MS = 16'h0040;
  // Pulse input polarity codes
  localparam logic [15:0] PPM_NORMAL = 16'h0000;
  localparam logic [15:0] PPM_INVERT = 16'h00FF;
  // Identity codes of states
  localparam logic [7:0] ID_NONE = 8'h00;
  localparam logic [7:0] ID_ERROR = 8'h01;
  localparam logic [7:0] ID_GPIO0 = 8'h08;
  localparam logic [7:0] ID_GDIN0 = 8'h10;
  localparam logic [7:0] ID_CH1 = 8'h30;
  localparam logic [7:0] ID_CH2 = 8'h31;
  localparam logic [7:0] ID_ICHG = 8'h40;
  localparam logic [7:0] ID_UCHG = 8'h41;
  localparam logic [7:0] ID_GNDIO = 8'h42;
  localparam logic [7:0] ID_CONT = 8'h80;
  // Level thresholds in mV
  localparam logic signed [16:0] TH_NEG_MV = 17'sh00258;
  localparam logic signed [16:0] TH_L1_MV = 17'sh00A28;
  localparam logic signed [16:0] TH_L2_MV = 17'sh01068;
  localparam logic signed [16:0] TH_L3_FLOAT_MV = 17'sh01E78;
  localparam logic signed [16:0] TH_L3_PU_MV = 17'sh01A90;
  localparam logic signed [16:0] TH_L3_PD_MV = 17'sh02A30;
  // Pull compensation: pull-up rail and divider weight as a shift
  localparam logic signed [16:0] PULL_RAIL_MV = 17'sh01388;
  localparam int COMP_SHIFT = 4;
  // Limits and reset values
  localparam logic [15:0] BEEP_MAX = 16'h03E8;
  localparam logic [15:0] PULSE_SAT = 16'h7FFF;
  localparam logic [15:0] SERVO_SAT = 16'hFFFF;
  localparam logic [6:0] PWM_STEPS = 7'h64;
  localparam logic [7:0] ATTACK_RST = 8'h64;
  localparam logic [7:0] HOLD_RST = 8'h32;
  localparam logic [15:0] ATTACKTIME_RST = 16'h0064;
  localparam logic [16:0] MV_PER_V_X100 = 17'h186A0;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS = 1000;
  localparam int MS_US = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    CIO_IDLE = 2'b00,
    CIO_ATTACK = 2'b01,
    CIO_HOLD = 2'b10
  } cio_cont_t;
endpackage : cio_pkg

// ---- rtl/cio_top.sv ----
// Common input/output block: pin bias, level codes, pulse and servo timing,
// charger readings, state identity lookup and contactor PWM driver.
// Assumes synchronous inputs, converted voltages in mV, classic Wishbone master.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cio_top
  import cio_pkg::*;
#(
  parameter logic [31:0] SIGNATURE = 32'h0000005A // Arbitrary value
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [79:0] pinMv,
  input wire logic [4:0] pinLevel,
  output logic [4:0] pullUpEn,
  output logic [4:0] pullDnEn,
  input wire logic servoIn1,
  input wire logic servoIn2,
  input wire logic [15:0] chgCurRaw,
  input wire logic [15:0] chgVolRaw,
  input wire logic [15:0] gndioRaw,
  input wire logic [15:0] battMv,
  input wire logic flipFlopFitted,
  output logic contDrainOut,
  output logic contDrainOe,
  output logic powerSwitchOn,
  output logic [1:0] contExtraOn,
  output logic auxOutputTwo,
  output logic powerOffReq,
  output logic motorTempEn,
  output logic [15:0] motorTempValue,
  output logic [15:0] toneVolume,
  output logic [7:0] appSelect
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Time bases
  logic [7:0] usCnt_reg;
  logic [9:0] msCnt_reg;
  wire usTick = (usCnt_reg == 8'(US_CYCLES - 1));
  wire msTick = usTick && (msCnt_reg == 10'(MS_US - 1));
  always_ff @(posedge mclk) begin
    if (rst || usTick) usCnt_reg <= 8'h00;
    else usCnt_reg <= usCnt_reg + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (rst || msTick) msCnt_reg <= 10'h000;
    else if (usTick) msCnt_reg <= msCnt_reg + 10'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and write strobes
  logic ackReg;
  wire busReq = wb_cyc_i && wb_stb_i && !ackReg;
  wire wrEn = busReq && wb_we_i;
  wire [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                         {8{wb_sel_i[0]}}};
  wire [15:0] wMask = selMask[15:0];
  wire wrMtemp = wrEn && (wb_adr_i == OFS_MTEMPSEL);
  wire wrBeep = wrEn && (wb_adr_i == OFS_BEEPVOL);
  wire wrApp = wrEn && (wb_adr_i == OFS_APPSEL);
  wire wrPpm = wrEn && (wb_adr_i == OFS_PPMCONF);
  wire wrCont = wrEn && (wb_adr_i == OFS_CONTCMD) && wb_sel_i[0] && wb_sel_i[1];
  wire wrShut = wrEn && (wb_adr_i == OFS_SHUTDOWN) && wb_sel_i[0];
  wire wrAtk = wrEn && (wb_adr_i == OFS_ATTACK);
  wire wrAtkT = wrEn && (wb_adr_i == OFS_ATTACKTIME);
  wire wrHold = wrEn && (wb_adr_i == OFS_HOLD);
  wire wrIdq = wrEn && (wb_adr_i == OFS_IDQUERY);
  wire [1:0] contNum = wb_dat_i[CONT_NUM_LSB +: 2];
  wire contOnCmd = wb_dat_i[CONT_ON_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0] mtempsel_reg, appsel_reg, attack_reg, hold_reg, idq_reg;
  logic [15:0] beep_reg, ppm_reg, atkTime_reg;
  logic [3:0] contOn_reg;
  logic aux_reg, powerOff_reg;
  wire [15:0] beepMerged = (beep_reg & ~wMask) | (wb_dat_i[15:0] & wMask);
  wire [15:0] beep_next = (beepMerged > BEEP_MAX) ? BEEP_MAX : beepMerged;
  always_ff @(posedge mclk) begin
    if (rst) begin
      mtempsel_reg <= 8'h00;
      appsel_reg <= 8'h00;
      beep_reg <= 16'h0000;
      ppm_reg <= PPM_NORMAL;
      attack_reg <= ATTACK_RST;
      hold_reg <= HOLD_RST;
      atkTime_reg <= ATTACKTIME_RST;
      idq_reg <= ID_NONE;
    end else begin
      if (wrMtemp && wb_sel_i[0]) mtempsel_reg <= wb_dat_i[7:0];
      if (wrApp && wb_sel_i[0]) appsel_reg <= wb_dat_i[7:0];
      if (wrBeep) beep_reg <= beep_next;
      if (wrPpm) ppm_reg <= (ppm_reg & ~wMask) | (wb_dat_i[15:0] & wMask);
      if (wrAtk && wb_sel_i[0]) attack_reg <= wb_dat_i[7:0];
      if (wrHold && wb_sel_i[0]) hold_reg <= wb_dat_i[7:0];
      if (wrAtkT) atkTime_reg <= (atkTime_reg & ~wMask) | (wb_dat_i[15:0] & wMask);
      if (wrIdq && wb_sel_i[0]) idq_reg <= wb_dat_i[7:0];
    end
  end
  // Command outputs; aux latches until reset since power goes away, power-off takes flipFlopFitted at each shutdown write with bit 0 set
  always_ff @(posedge mclk) begin
    if (rst) begin
      contOn_reg <= 4'h0;
      aux_reg <= 1'b0;
      powerOff_reg <= 1'b0;
    end else begin
      if (wrCont) contOn_reg[contNum] <= contOnCmd;
      if (wrShut && wb_dat_i[SHUT_BIT]) begin
        aux_reg <= 1'b1;
        powerOff_reg <= flipFlopFitted;
      end
    end
  end
  assign powerSwitchOn = contOn_reg[0];
  assign contExtraOn = contOn_reg[3:2];
  assign auxOutputTwo = aux_reg;
  assign powerOffReq = powerOff_reg;
  assign toneVolume = beep_reg;
  assign appSelect = appsel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per pin: bias, compensation, level code, pulse measurement
  logic [15:0] ioconf_reg [NPINS];
  logic [15:0] gpioVal_reg [NPINS];
  logic [7:0] gdin_reg [NPINS];
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : gPin
      wire wrConf = wrEn && (wb_adr_i == OFS_IOCONF0 + 8'(4 * gi));
      wire isPu = (ioconf_reg[gi] == CONF_PULLUP);
      wire isPd = (ioconf_reg[gi] == CONF_PULLDN);
      wire isUs = (ioconf_reg[gi] == CONF_PULSE_US);
      wire isMs = (ioconf_reg[gi] == CONF_PULSE_MS);
      wire signed [16:0] raw = 17'(signed'(pinMv[16 * gi +: 16]));
      // Divider error estimated by a shift; avoids a divider per pin
      wire signed [16:0] comp = isPu ? raw + ((raw - PULL_RAIL_MV) >>> COMP_SHIFT)
                              : isPd ? raw + (raw >>> COMP_SHIFT) : raw;
      wire signed [16:0] top = isPu ? TH_L3_PU_MV : isPd ? TH_L3_PD_MV
                             : TH_L3_FLOAT_MV;
      wire [7:0] lvl = (comp > top) ? 8'h03 : (comp > TH_L2_MV) ? 8'h02
                     : (comp > TH_L1_MV) ? 8'h01
                     : (isPu && comp < TH_NEG_MV) ? 8'hFF : 8'h00;
      logic lvlDly_reg;
      logic [15:0] pCnt_reg;
      wire pTick = isMs ? msTick : usTick;
      wire fall = lvlDly_reg && !pinLevel[gi];
      assign pullUpEn[gi] = isPu;
      assign pullDnEn[gi] = isPd;
      always_ff @(posedge mclk) begin
        if (rst) ioconf_reg[gi] <= CONF_FLOAT;
        else if (wrConf) ioconf_reg[gi] <= (ioconf_reg[gi] & ~wMask)
                                          | (wb_dat_i[15:0] & wMask);
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          lvlDly_reg <= 1'b0;
          pCnt_reg <= 16'h0000;
          gpioVal_reg[gi] <= 16'h0000;
          gdin_reg[gi] <= 8'h00;
        end else begin
          lvlDly_reg <= pinLevel[gi];
          gdin_reg[gi] <= lvl;
          if (!(isUs || isMs)) gpioVal_reg[gi] <= 16'(comp);
          else if (fall) gpioVal_reg[gi] <= pCnt_reg;
          if (!pinLevel[gi] || !(isUs || isMs)) pCnt_reg <= 16'h0000;
          else if (pTick && pCnt_reg != PULSE_SAT) pCnt_reg <= pCnt_reg + 16'h0001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Servo channels, polarity, charger readings
  wire inv = (ppm_reg == PPM_INVERT);
  wire [1:0] servoLvl = {servoIn2, servoIn1} ^ {2{inv}};
  logic [1:0] servoDly_reg;
  logic [15:0] sCnt_reg [2];
  logic [15:0] ch_reg [2];
  logic [15:0] ichg_reg, uchg_reg, gndio_reg;
  generate
    for (gi = 0; gi < 2; gi++) begin : gServo
      always_ff @(posedge mclk) begin
        if (rst) begin
          servoDly_reg[gi] <= 1'b0;
          sCnt_reg[gi] <= 16'h0000;
          ch_reg[gi] <= 16'h0000;
        end else begin
          servoDly_reg[gi] <= servoLvl[gi];
          if (servoDly_reg[gi] && !servoLvl[gi]) ch_reg[gi] <= sCnt_reg[gi];
          if (!servoLvl[gi]) sCnt_reg[gi] <= 16'h0000;
          else if (usTick && sCnt_reg[gi] != SERVO_SAT) sCnt_reg[gi] <= sCnt_reg[gi] + 16'h0001;
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (rst) begin
      ichg_reg <= 16'h0000;
      uchg_reg <= 16'h0000;
      gndio_reg <= 16'h0000;
    end else begin
      ichg_reg <= chgCurRaw;
      uchg_reg <= chgVolRaw;
      gndio_reg <= gndioRaw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Contactor one: pull-in then hold PWM, open drain
  cio_cont_t st_reg, st_next;
  logic [15:0] atkMs_reg;
  logic [6:0] pwmCnt_reg;
  logic pwmOn_reg;
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      CIO_IDLE: if (contOn_reg[1]) st_next = CIO_ATTACK;
      CIO_ATTACK: if (atkMs_reg >= atkTime_reg) st_next = CIO_HOLD;
      CIO_HOLD: st_next = CIO_HOLD;
      default: st_next = CIO_IDLE;
    endcase
    if (!contOn_reg[1]) st_next = CIO_IDLE;
  end
  // Setting follows the next state so the registered drive matches the state it lands in
  wire [7:0] setting = (st_next == CIO_ATTACK) ? attack_reg : hold_reg;
  wire [6:0] pct = (setting > 8'(PWM_STEPS)) ? PWM_STEPS : setting[6:0];
  wire [7:0] volts = 8'(-signed'(setting));
  wire [22:0] rampMv = 23'(pwmCnt_reg) * 23'(battMv);
  wire [24:0] wantMv = 25'(volts) * 25'(MV_PER_V_X100);
  wire dutyHit = setting[7] ? (25'(rampMv) < wantMv) : (pwmCnt_reg < pct);
  // Off clears the drive on the same edge that clears the state bit
  wire contOffNow = wrCont && (contNum == 2'd1) && !contOnCmd;
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= CIO_IDLE;
      atkMs_reg <= 16'h0000;
      pwmCnt_reg <= 7'h00;
      pwmOn_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (st_next != CIO_ATTACK) atkMs_reg <= 16'h0000;
      else if (msTick) atkMs_reg <= atkMs_reg + 16'h0001;
      if (usTick) pwmCnt_reg <= (pwmCnt_reg == PWM_STEPS - 7'h01) ? 7'h00
                                : pwmCnt_reg + 7'h01;
      pwmOn_reg <= (st_next != CIO_IDLE) && dutyHit && !contOffNow;
    end
  end
  assign contDrainOut = 1'b0;
  assign contDrainOe = pwmOn_reg;

  ////////////////////////////////////////////////////////////////////////////
  // State lookup by ID
  function automatic logic [16:0] idLookup(input logic [7:0] id);
    logic [16:0] r;
    r = {1'b0, 16'h0000};
    if (id >= ID_GPIO0 && id < ID_GPIO0 + 8'(NPINS))
      r = {1'b1, gpioVal_reg[3'(id - ID_GPIO0)]};
    else if (id >= ID_GDIN0 && id < ID_GDIN0 + 8'(NPINS))
      r = {1'b1, {8{gdin_reg[3'(id - ID_GDIN0)][7]}}, gdin_reg[3'(id - ID_GDIN0)]};
    else if (id == ID_CH1) r = {1'b1, ch_reg[0]};
    else if (id == ID_CH2) r = {1'b1, ch_reg[1]};
    else if (id == ID_ICHG) r = {1'b1, ichg_reg};
    else if (id == ID_UCHG) r = {1'b1, uchg_reg};
    else if (id == ID_GNDIO) r = {1'b1, gndio_reg};
    else if (id == ID_CONT) r = {1'b1, 15'h0000, contOn_reg[1]};
    return r;
  endfunction : idLookup
  // Process form: a change in any looked-up state re-runs the lookup
  logic [16:0] idqHit;
  logic [16:0] tempHit;
  always_comb begin
    idqHit = idLookup(idq_reg);
    tempHit = idLookup(mtempsel_reg);
  end
  // Unknown IDs answer with the error code
  wire [15:0] idqVal = idqHit[16] ? idqHit[15:0] : {8'h00, ID_ERROR};
  assign motorTempEn = (mtempsel_reg != ID_NONE);
  assign motorTempValue = (motorTempEn && tempHit[16]) ? tempHit[15:0] : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and ack
  wire [7:0] pinOfs = wb_adr_i - OFS_IOCONF0;
  wire [2:0] pinIdx = pinOfs[4:2];
  wire pinOk = (pinIdx < 3'(NPINS)) && (pinOfs[1:0] == 2'b00);
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    case (wb_adr_i)
      OFS_SIG: rdMux = SIGNATURE;
      OFS_MTEMPSEL: rdMux = {24'h000000, mtempsel_reg};
      OFS_BEEPVOL: rdMux = {16'h0000, beep_reg};
      OFS_APPSEL: rdMux = {24'h000000, appsel_reg};
      OFS_PPMCONF: rdMux = {16'h0000, ppm_reg};
      OFS_CONTCMD: rdMux = {28'h0000000, contOn_reg};
      OFS_SHUTDOWN: rdMux = {30'h00000000, powerOff_reg, aux_reg};
      OFS_ATTACK: rdMux = {24'h000000, attack_reg};
      OFS_ATTACKTIME: rdMux = {16'h0000, atkTime_reg};
      OFS_HOLD: rdMux = {24'h000000, hold_reg};
      OFS_CH1: rdMux = {16'h0000, ch_reg[0]};
      OFS_CH2: rdMux = {16'h0000, ch_reg[1]};
      OFS_ICHG: rdMux = {{16{ichg_reg[15]}}, ichg_reg};
      OFS_UCHG: rdMux = {{16{uchg_reg[15]}}, uchg_reg};
      OFS_GNDIO: rdMux = {{16{gndio_reg[15]}}, gndio_reg};
      OFS_IDQUERY: rdMux = {24'h000000, idq_reg};
      OFS_IDVALUE: rdMux = {16'h0000, idqVal};
      default: begin
        if (pinOk && pinOfs[7:5] == 3'h0) rdMux = {16'h0000, ioconf_reg[pinIdx]};
        else if (pinOk && pinOfs[7:5] == 3'h1)
          rdMux = {{16{gpioVal_reg[pinIdx][15]}}, gpioVal_reg[pinIdx]};
        else if (pinOk && pinOfs[7:5] == 3'h2)
          rdMux = {{24{gdin_reg[pinIdx][7]}}, gdin_reg[pinIdx]};
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      ackReg <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ackReg <= busReq;
      if (busReq && !wb_we_i) wb_dat_o <= rdMux;
    end
  end
  assign wb_ack_o = ackReg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  bias_select_a: assert property (pullUpEn[0] |-> ioconf_reg[0] == CONF_PULLUP && !pullDnEn[0])
    else $error("pull-up without config 1");
  sequence sFallUs;
    gPin[0].isUs && gPin[0].fall;
  endsequence
  pulse_us_a: assert property (sFallUs |=> gpioVal_reg[0] == $past(gPin[0].pCnt_reg))
    else $error("pulse length not latched");
  neg_level_a: assert property (gdin_reg[1] == 8'hFF |-> $past(gPin[1].isPu))
    else $error("level -1 without pull-up");
  od_drive_a: assert property (contDrainOe |-> contDrainOut == 1'b0 && contOn_reg[1])
    else $error("drain driven while off");
  sequence sContOff;
    wrCont && contNum == 2'd1 && !contOnCmd;
  endsequence
  off_force_a: assert property (sContOff |=> !contDrainOe)
    else $error("pwm still on after off");
  sequence sClose;
    st_reg == CIO_IDLE && contOn_reg[1];
  endsequence
  pull_in_a: assert property (sClose |=> st_reg == CIO_ATTACK)
    else $error("close did not start pull-in");
  beep_limit_a: assert property (toneVolume <= BEEP_MAX)
    else $error("tone volume above limit");
  sig_read_a: assert property (busReq && !wb_we_i && wb_adr_i == OFS_SIG
    |=> wb_ack_o && wb_dat_o == SIGNATURE)
    else $error("signature read wrong");
  shut_aux_a: assert property (wrShut && wb_dat_i[SHUT_BIT] |=> auxOutputTwo
    && powerOffReq == $past(flipFlopFitted))
    else $error("shutdown effects missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : cio_top
